//--- phy_basic_control_reg.v
/*
 * Basic control register of a 10/100 line transceiver, index zero of the
 * management register space, with strap override and the mode outputs it
 * steers (loopback, rate, duplex, isolate, low power, collision test).
 * Assumes a management frame engine on clk_i that issues one-cycle read
 * and write strobes with a register index and 16-bit data, an autoneg
 * engine that reports its outcome, and strap pins that are static.
 */
//
// Overview of operation
// - 16-bit control register at index zero
// - Bit 15 write starts software reset
// - Bit 15 reads one, accesses ignored meanwhile; reads refused, so the one is never seen
// - Loopback disables line, loops MAC data
// - Loopback receive valid within 512 bits
// - Collision test keeps collision detect in loopback
// - Hardware mode takes rate from strap
// - Hardware mode reports rate in index 17
// - Autoneg enabled ignores rate and duplex bits
// - Bit 13 selects 10 or 100 Mbps
// - Hardware mode takes autoneg from strap
// - Bit 12 enables autoneg in software mode
// - Low power disables functions, MAC outputs low
// - Low power tri-states line transmit outputs
// - Low power keeps registers, clears latched flags
// - Reset value 0x3000, isolate if address zero
// - Isolate floats MAC outputs, ignores inputs
// - Restart bit self-clears, ignored without autoneg; ignored in hardware mode even with strap autoneg on
// - Bit 8 selects duplex unless overridden
// - Reserved bits read as zero
`timescale 1ns/100ps
`default_nettype none
`include "phy_basic_control_defines.vh"

module phy_basic_control_reg #(
  parameter RESET_CYCLES = 16
) (
  input  wire        clk_i,
  input  wire        rst_b_i,
  // Management access
  input  wire        mgmt_wr_i,
  input  wire        mgmt_rd_i,
  input  wire [4:0]  mgmt_idx_i,
  input  wire [15:0] mgmt_wdata_i,
  output reg  [15:0] mgmt_rdata_o,
  output reg         mgmt_rvalid_o,
  // Straps and latched address
  input  wire        config_mode_strap_pin_i,
  input  wire        rate_strap_pin_i,
  input  wire        autoneg_strap_pin_i,
  input  wire        duplex_strap_pin_i,
  input  wire [4:0]  phy_addr_i,
  // Autoneg engine
  input  wire        an_rate_100_i,
  input  wire        an_full_duplex_i,
  input  wire        an_started_i,
  // MAC side
  input  wire        mac_tx_en_i,
  input  wire [3:0]  mac_txd_i,
  input  wire        line_rx_dv_i,
  input  wire [3:0]  line_rxd_i,
  input  wire        line_col_i,
  output reg         mac_rx_dv_o,
  output reg  [3:0]  mac_rxd_o,
  output reg         mac_col_o,
  output reg         mac_out_oe_b_o,
  // Mode outputs
  output reg         line_tx_en_o,
  output reg         line_rx_en_o,
  output reg         line_tx_tristate_o,
  output reg         col_det_en_o,
  output reg         rate_100_o,
  output reg         full_duplex_o,
  output reg         an_enable_o,
  output reg         an_restart_o,
  output reg         fsm_idle_o,
  output reg         latch_flags_clear_o
);

  // ---------------------------------------------------------------
  // Reset synchroniser and strap synchronisers
  // ---------------------------------------------------------------
  reg  [1:0] rst_sync_q;
  wire       rst_b;
  reg  [3:0] strap_s1_q;
  reg  [3:0] strap_s2_q;
  reg  [4:0] addr_s1_q;
  reg  [4:0] addr_s2_q;

  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_b = rst_sync_q[1];

  // Runs through reset so the address is settled when INIT samples it
  always @(posedge clk_i) begin
    strap_s1_q <= {config_mode_strap_pin_i, rate_strap_pin_i,
                   autoneg_strap_pin_i, duplex_strap_pin_i};
    strap_s2_q <= strap_s1_q;
    addr_s1_q  <= phy_addr_i;
    addr_s2_q  <= addr_s1_q;
  end

  wire sw_mode    = strap_s2_q[3];
  wire strap_rate = strap_s2_q[2];
  wire strap_an   = strap_s2_q[1];
  wire strap_dpx  = strap_s2_q[0];

  // ---------------------------------------------------------------
  // Control register
  // ---------------------------------------------------------------
  localparam [2:0] ST_INIT  = 3'h1;
  localparam [2:0] ST_RUN   = 3'h2;
  localparam [2:0] ST_SWRST = 3'h4;

  reg  [2:0]  state_q;
  reg  [15:0] ctrl_q;
  reg  [7:0]  rst_cnt_q;
  reg  [15:0] ctrl_d;
  wire [15:0] ctrl_default;
  wire        wr_ctrl;
  wire        an_en_eff;

  // Isolate default follows the latched address
  assign ctrl_default = `CTRL_RESET_VALUE |
    {5'h00, (addr_s2_q == 5'h00), 10'h000};
  assign wr_ctrl = mgmt_wr_i && (state_q == ST_RUN) &&
                   (mgmt_idx_i == `CTRL_REG_IDX);
  assign an_en_eff = sw_mode ? ctrl_q[`CTRL_AN_EN_BIT] : strap_an;

  always @* begin
    ctrl_d = ctrl_q;
    if (wr_ctrl) begin
      ctrl_d = mgmt_wdata_i & `CTRL_RSVD_MASK;
      if (!(sw_mode && mgmt_wdata_i[`CTRL_AN_EN_BIT])) begin
        ctrl_d[`CTRL_AN_RESTART_BIT] = 1'b0;
      end
    end else if (an_started_i) begin
      ctrl_d[`CTRL_AN_RESTART_BIT] = 1'b0;
    end
  end

  always @(posedge clk_i or negedge rst_b) begin
    if (!rst_b) begin
      state_q   <= ST_INIT;
      ctrl_q    <= `CTRL_RESET_VALUE;
      rst_cnt_q <= 8'h00;
    end else begin
      case (state_q)
        ST_INIT: begin
          ctrl_q  <= ctrl_default;
          state_q <= ST_RUN;
        end
        ST_RUN: begin
          if (wr_ctrl && mgmt_wdata_i[`CTRL_SW_RESET_BIT]) begin
            ctrl_q    <= ctrl_default | 16'h8000;
            rst_cnt_q <= RESET_CYCLES[7:0];
            state_q   <= ST_SWRST;
          end else begin
            ctrl_q <= ctrl_d;
          end
        end
        ST_SWRST: begin
          if (rst_cnt_q == 8'h00) begin
            ctrl_q  <= ctrl_default;
            state_q <= ST_RUN;
          end else begin
            rst_cnt_q <= rst_cnt_q - 8'h01;
          end
        end
        default: begin
          state_q <= ST_INIT;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Register reads
  // ---------------------------------------------------------------
  wire rd_ok = mgmt_rd_i && (state_q != ST_SWRST);
  wire rate_eff;
  wire dpx_eff;

  always @(posedge clk_i or negedge rst_b) begin
    if (!rst_b) begin
      mgmt_rdata_o  <= 16'h0000;
      mgmt_rvalid_o <= 1'b0;
    end else begin
      mgmt_rvalid_o <= rd_ok;
      if (rd_ok && mgmt_idx_i == `CTRL_REG_IDX) begin
        mgmt_rdata_o <= ctrl_q & `CTRL_RSVD_MASK;
      end else if (rd_ok && mgmt_idx_i == `DSTAT_REG_IDX) begin
        mgmt_rdata_o <= {rate_eff, dpx_eff, 14'h0000};
      end else if (rd_ok) begin
        mgmt_rdata_o <= 16'h0000;
      end
    end
  end

  // ---------------------------------------------------------------
  // Mode resolution
  // ---------------------------------------------------------------
  wire loop_on  = ctrl_q[`CTRL_LOOPBACK_BIT];
  wire low_pwr  = ctrl_q[`CTRL_LOW_POWER_BIT];
  wire isolate  = ctrl_q[`CTRL_ISOLATE_BIT];
  wire col_test = ctrl_q[`CTRL_COL_TEST_BIT];

  wire an_rate_100 = an_rate_100_i;

  assign rate_eff = !sw_mode ? strap_rate :
                    an_en_eff ? an_rate_100 :
                    ctrl_q[`CTRL_RATE_BIT];
  assign dpx_eff = loop_on ? 1'b0 :
                   !sw_mode ? strap_dpx :
                   an_en_eff ? an_full_duplex_i :
                   ctrl_q[`CTRL_DUPLEX_BIT];

  // ---------------------------------------------------------------
  // MAC side and line controls
  // ---------------------------------------------------------------
  reg  [3:0] loop_dly_q;
  wire       mac_tx_en = mac_tx_en_i && !isolate;
  wire       active    = !low_pwr && (state_q == ST_RUN);
  wire       sel_dv    = loop_on ? loop_dly_q[0] : line_rx_dv_i;

  always @(posedge clk_i or negedge rst_b) begin
    if (!rst_b) begin
      loop_dly_q          <= 4'h0;
      mac_rx_dv_o         <= 1'b0;
      mac_rxd_o           <= 4'h0;
      mac_col_o           <= 1'b0;
      mac_out_oe_b_o      <= 1'b1;
      line_tx_en_o        <= 1'b0;
      line_rx_en_o        <= 1'b0;
      line_tx_tristate_o  <= 1'b1;
      col_det_en_o        <= 1'b0;
      rate_100_o          <= 1'b1;
      full_duplex_o       <= 1'b0;
      an_enable_o         <= 1'b0;
      an_restart_o        <= 1'b0;
      fsm_idle_o          <= 1'b1;
      latch_flags_clear_o <= 1'b0;
    end else begin
      loop_dly_q <= {mac_tx_en && loop_on, loop_dly_q[3:1]};
      if (!active) begin
        mac_rx_dv_o <= 1'b0;
        mac_rxd_o   <= 4'h0;
        mac_col_o   <= 1'b0;
      end else begin
        mac_rx_dv_o <= sel_dv;
        mac_rxd_o   <= loop_on ? mac_txd_i : line_rxd_i;
        mac_col_o   <= col_test ? mac_tx_en :
                       (!loop_on && line_col_i);
      end
      mac_out_oe_b_o     <= isolate;
      line_tx_en_o       <= active && !loop_on;
      line_rx_en_o       <= active && !loop_on;
      line_tx_tristate_o <= !active;
      col_det_en_o       <= active && (!loop_on || col_test);
      rate_100_o         <= rate_eff;
      full_duplex_o      <= dpx_eff;
      an_enable_o        <= active && an_en_eff;
      an_restart_o       <= wr_ctrl && sw_mode && active &&
                            mgmt_wdata_i[`CTRL_AN_EN_BIT] &&
                            mgmt_wdata_i[`CTRL_AN_RESTART_BIT];
      fsm_idle_o         <= (state_q != ST_RUN);
      latch_flags_clear_o <= wr_ctrl &&
                             mgmt_wdata_i[`CTRL_LOW_POWER_BIT] &&
                             !low_pwr;
    end
  end

endmodule // phy_basic_control_reg
`default_nettype wire

//--- phy_basic_control_defines.vh
/*
 * Constants for the basic control register of a 10/100 line transceiver:
 * register index, field positions, reset values and timing counts.
 * Assumes inclusion by bare name from plain Verilog design files.
 */
`ifndef PHY_BASIC_CONTROL_DEFINES_VH
`define PHY_BASIC_CONTROL_DEFINES_VH

// ---------------------------------------------------------------
// Register indices
// ---------------------------------------------------------------
`define CTRL_REG_IDX        5'h00
`define DSTAT_REG_IDX       5'h11

// ---------------------------------------------------------------
// Control and status register fields
// ---------------------------------------------------------------
`define CTRL_SW_RESET_BIT   15
`define CTRL_LOOPBACK_BIT   14
`define CTRL_RATE_BIT       13
`define CTRL_AN_EN_BIT      12
`define CTRL_LOW_POWER_BIT  11
`define CTRL_ISOLATE_BIT    10
`define CTRL_AN_RESTART_BIT 9
`define CTRL_DUPLEX_BIT     8
`define CTRL_COL_TEST_BIT   7
`define CTRL_RSVD_MASK      16'hff80
`define CTRL_RESET_VALUE    16'h3000
`define DSTAT_RATE_BIT      15
`define DSTAT_DUPLEX_BIT    14

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define SW_RESET_CYCLES     8'h10
`define LOOP_LIMIT_BITS     512
`define LOOP_DELAY_CYCLES   4'h2

`endif

//--- phy_basic_control_reg_props.sv
/* Port checker for the basic control register.
   Assumes binding to the design top; clk_i domain only. */
`timescale 1ns/100ps
`default_nettype none
module phy_basic_control_reg_props (
  input wire        clk_i,
  input wire        rst_b_i,
  input wire        mgmt_wr_i,
  input wire        mgmt_rd_i,
  input wire [15:0] mgmt_wdata_i,
  input wire [15:0] mgmt_rdata_o,
  input wire        mgmt_rvalid_o,
  input wire        mac_tx_en_i,
  input wire        mac_rx_dv_o,
  input wire [3:0]  mac_rxd_o,
  input wire        mac_col_o,
  input wire        mac_out_oe_b_o,
  input wire        line_tx_en_o,
  input wire        line_rx_en_o,
  input wire        line_tx_tristate_o,
  input wire        an_enable_o,
  input wire        an_restart_o,
  input wire        fsm_idle_o,
  input wire        latch_flags_clear_o
);
  // ---------------------------------------------
  // Properties
  // ---------------------------------------------
  wire loop = !line_tx_en_o && !line_rx_en_o && !line_tx_tristate_o
              && !fsm_idle_o;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  property p_rsvd; mgmt_rvalid_o |-> mgmt_rdata_o[6:0] == 7'h00; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
  property p_rvalid;
    mgmt_rvalid_o |-> $past(mgmt_rd_i) || $past(mgmt_rd_i, 2);
  endproperty
  a_rvalid: assert property (p_rvalid) else $error("stray rvalid");
  property p_refuse;
    mgmt_rd_i && fsm_idle_o ##1 fsm_idle_o |-> !mgmt_rvalid_o;
  endproperty
  a_refuse: assert property (p_refuse) else $error("read in reset");
  property p_swrst;
    mgmt_wr_i && mgmt_wdata_i[15] && !fsm_idle_o |-> ##[1:3] fsm_idle_o;
  endproperty
  a_swrst: assert property (p_swrst) else $error("no soft reset");
  property p_loop;
    loop && !mac_out_oe_b_o && $rose(mac_tx_en_i) |-> ##[1:100] mac_rx_dv_o;
  endproperty
  a_loop: assert property (p_loop) else $error("loop too slow");
  property p_lp;
    line_tx_tristate_o && $past(line_tx_tristate_o) && !fsm_idle_o
      && !$past(fsm_idle_o) |-> !mac_rx_dv_o && mac_rxd_o == 4'h0 && !mac_col_o;
  endproperty
  a_lp: assert property (p_lp) else $error("mac out in low power");
  property p_restart; an_restart_o |=> an_enable_o; endproperty
  a_restart: assert property (p_restart) else $error("bad restart");
  property p_iso;
    $changed(mac_out_oe_b_o) && !fsm_idle_o && !$past(fsm_idle_o)
      && !$past(fsm_idle_o, 2) |-> $past(mgmt_wr_i) || $past(mgmt_wr_i, 2);
  endproperty
  a_iso: assert property (p_iso) else $error("isolate moved");
  property p_lfc;
    latch_flags_clear_o |-> $past(mgmt_wr_i) && $past(mgmt_wdata_i[11]);
  endproperty
  a_lfc: assert property (p_lfc) else $error("stray flag clear");
endmodule // phy_basic_control_reg_props
bind phy_basic_control_reg phy_basic_control_reg_props u_props (.*);
`default_nettype wire

//--- mgmt_station_model.sv
/* Management station model issuing register strobes.
   Assumes strobes are taken on the rising clk_i edge. */
`timescale 1ns/100ps
`default_nettype none
module mgmt_station_model (
  input  wire logic        clk_i,
  input  wire logic [15:0] rdata_i,
  input  wire logic        rvalid_i,
  output var  logic        wr_o,
  output var  logic        rd_o,
  output var  logic [4:0]  idx_o,
  output var  logic [15:0] wdata_o
);
  // ---------------------------------------------
  // Access tasks
  // ---------------------------------------------
  initial begin
    {wr_o, rd_o, idx_o, wdata_o} = '0;
  end
  task automatic wr(input logic [4:0] i, input logic [15:0] v, input bit raw);
    @(negedge clk_i);
    idx_o = i;
    wdata_o = raw ? v : v & 16'hff80;
    wr_o = 1'b1;
    @(negedge clk_i);
    wr_o = 1'b0;
    wdata_o = ~wdata_o;
  endtask
  task automatic rd(input logic [4:0] i, output logic [15:0] v, output bit ok);
    v = 'x;
    ok = 0;
    @(negedge clk_i);
    idx_o = i;
    rd_o = 1'b1;
    @(negedge clk_i);
    rd_o = 1'b0;
    repeat (3) begin
      if (rvalid_i === 1'b1) begin
        ok = 1;
        v = rdata_i;
      end
      @(negedge clk_i);
    end
  endtask
  task automatic poll;
    logic [15:0] v;
    bit ok;
    ok = 0;
    for (int k = 0; k < 40 && !(ok && v[15] === 1'b0); k++) begin
      rd(5'h00, v, ok);
    end
  endtask
endmodule // mgmt_station_model
`default_nettype wire

//--- phy_basic_control_reg_tb.sv
/* Self-checking bench for the basic control register.
   Assumes the station model and the bound port checker. */
`timescale 1ns/100ps
`default_nettype none
module phy_basic_control_reg_tb;
  // ---------------------------------------------
  // Signals and instances
  // ---------------------------------------------
  logic clk_i = 0, rst_b_i = 0, cfg = 1, rs = 0, ans = 0, dps = 0;
  logic txen = 0, an_r = 0, an_f = 0, an_s = 0, lrdv = 1, lcol = 0;
  logic [4:0] addr = 0, idx;
  logic [3:0] txd = 0, lrxd = 0, rxd;
  logic [15:0] wd, rdv, d, w;
  logic wr, rd, rv, rxdv, col, oeb, ltx, lrx, tst, cde, r100, fdx, ane;
  int n_fail = 0, num_checks = 0, cyc = 0;
  bit ok;
  always #10 clk_i = ~clk_i;
  mgmt_station_model u_sta (.clk_i(clk_i), .rdata_i(rdv), .rvalid_i(rv),
    .wr_o(wr), .rd_o(rd), .idx_o(idx), .wdata_o(wd));
  phy_basic_control_reg DUT (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .mgmt_wr_i(wr), .mgmt_rd_i(rd), .mgmt_idx_i(idx), .mgmt_wdata_i(wd),
    .mgmt_rdata_o(rdv), .mgmt_rvalid_o(rv), .config_mode_strap_pin_i(cfg),
    .rate_strap_pin_i(rs), .autoneg_strap_pin_i(ans),
    .duplex_strap_pin_i(dps), .phy_addr_i(addr), .an_rate_100_i(an_r),
    .an_full_duplex_i(an_f), .an_started_i(an_s), .mac_tx_en_i(txen),
    .mac_txd_i(txd), .line_rx_dv_i(lrdv), .line_rxd_i(lrxd),
    .line_col_i(lcol), .mac_rx_dv_o(rxdv), .mac_rxd_o(rxd), .mac_col_o(col),
    .mac_out_oe_b_o(oeb), .line_tx_en_o(ltx), .line_rx_en_o(lrx),
    .line_tx_tristate_o(tst), .col_det_en_o(cde), .rate_100_o(r100),
    .full_duplex_o(fdx), .an_enable_o(ane), .an_restart_o(),
    .fsm_idle_o(), .latch_flags_clear_o());
  // ---------------------------------------------
  // Helpers
  // ---------------------------------------------
  function automatic logic [15:0] ex(input logic [15:0] v);
    ex = v & 16'h7f80;
    if (!v[12]) ex[9] = 1'b0;
  endfunction
  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] s, e);
    num_checks++;
    if (s !== e) begin
      n_fail++;
      $display("wrong value %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic rck(input logic [4:0] i, input logic [15:0] e);
    u_sta.rd(i, d, ok);
    chk("rdata", d, e);
  endtask
  task automatic wrs(input logic [15:0] v);
    u_sta.wr(5'h00, v, 0);
    repeat (3) @(negedge clk_i);
  endtask
  task automatic rst(input logic [4:0] a);
    addr = a;
    rst_b_i = 0;
    repeat (6) @(negedge clk_i);
    rst_b_i = 1;
    repeat (6) @(negedge clk_i);
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      complete_run;
    end
  end
  // ---------------------------------------------
  // Scenarios
  // ---------------------------------------------
  initial begin
    void'($urandom(32'hf4b9));
    rst(5'h00);
    rck(5'h00, 16'h3400);
    rst(5'h0a);
    rck(5'h00, 16'h3000);
    repeat (24) begin
      w = $urandom & 16'h77ff;
      an_r = $urandom;
      an_f = $urandom;
      wrs(w);
      rck(5'h00, ex(w));
      chk("an_en", ane, w[12]);
      chk("rate", r100, w[12] ? an_r : w[13]);
      chk("duplex", fdx, !w[14] && (w[12] ? an_f : w[8]));
    end
    u_sta.wr(5'h00, 16'h007f, 1);
    rck(5'h00, 16'h0000);
    cfg = 0;
    for (int i = 0; i < 2; i++) begin
      {rs, ans, an_r} = {3{i[0]}};
      dps = $urandom;
      an_f = dps;
      repeat (5) @(negedge clk_i);
      chk("hw rate", r100, rs);
      chk("hw an", ane, ans);
      rck(5'h11, {rs, dps, 14'h0});
    end
    cfg = 1;
    wrs(16'h4000);
    chk("line", {ltx, lrx, cde}, 0);
    txd = $urandom;
    txen = 1;
    for (int k = 0; k < 20 && rxdv !== 1'b1; k++) @(negedge clk_i);
    chk("rx_dv", rxdv, 1);
    chk("rxd", rxd, txd);
    wrs(16'h4080);
    chk("col_det", cde, 1);
    chk("col", col, 1);
    txen = 0;
    wrs(16'h0800);
    chk("tristate", tst, 1);
    chk("lp rx_dv", rxdv, 0);
    rck(5'h00, 16'h0800);
    wrs(16'h0400);
    chk("float", oeb, 1);
    rck(5'h00, 16'h0400);
    wrs(16'h1200);
    rck(5'h00, 16'h1200);
    an_s = 1;
    @(negedge clk_i);
    an_s = 0;
    rck(5'h00, 16'h1000);
    wrs(16'h0200);
    rck(5'h00, 16'h0000);
    u_sta.wr(5'h00, 16'h8000, 0);
    u_sta.rd(5'h00, d, ok);
    chk("refused", ok, 0);
    u_sta.poll;
    rck(5'h00, 16'h3000);
    complete_run;
  end
endmodule // phy_basic_control_reg_tb
`default_nettype wire
